// *** core/dsleep_gate_pkg.sv ***
// Constants, field layout and carrier types for the deep-sleep clock gating block.
// Assumes a 32-bit AXI4-Lite register bus and a single 100 MHz system clock.
package dsleep_gate_pkg;

  // Register byte offsets within the system control window.
  localparam logic [11:0] RUN_GATE_OFS = 12'h104;
  localparam logic [11:0] SLEEP_GATE_OFS = 12'h114;
  localparam logic [11:0] DEEP_GATE_OFS = 12'h124;
  localparam logic [11:0] CLK_CFG_OFS = 12'h060;
  localparam logic [11:0] IRQ_STATUS_OFS = 12'h140;
  localparam logic [11:0] IRQ_MASK_OFS = 12'h144;
  localparam logic [31:0] SYSCTL_BASE = 32'h400FE000;

  // Gate bit positions, and the automatic gating bit of the clock configuration.
  localparam int GP_COUNTER3_BIT = 19;
  localparam int GP_COUNTER2_BIT = 18;
  localparam int GP_COUNTER1_BIT = 17;
  localparam int GP_COUNTER0_BIT = 16;
  localparam int TWO_WIRE1_BIT = 14;
  localparam int TWO_WIRE0_BIT = 12;
  localparam int SYNC_SERIAL0_BIT = 4;
  localparam int ASYNC_SERIAL2_BIT = 2;
  localparam int ASYNC_SERIAL1_BIT = 1;
  localparam int ASYNC_SERIAL0_BIT = 0;
  localparam int AUTO_GATING_BIT = 27;

  // Writable bits of the gate registers; all others are reserved and read zero.
  localparam logic [31:0] GATE_WMASK = 32'h000F5017;
  localparam logic [31:0] GATE_RESET = 32'h00000000;
  localparam logic [31:0] CLK_CFG_WMASK = 32'h08000000;
  localparam logic [31:0] CLK_CFG_RESET = 32'h00000000;

  // Interrupt status layout.
  localparam int EV_FAULT_BIT = 0;
  localparam int EV_MODE_BIT = 1;
  localparam int EV_WIDTH = 2;
  localparam logic [1:0] EV_RESET = 2'h0;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Power mode of the system.
  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_SLEEP,
    MODE_DEEP
  } power_mode_t;

  // Peripheral-side access seen by the fault check.
  typedef struct packed {
    logic valid;
    logic [4:0] unit_idx;
  } unit_access_t;

  // Fault verdict returned to the peripheral bus.
  typedef struct packed {
    logic done;
    logic fault;
  } unit_verdict_t;

endpackage

// *** core/unit_access_check.sv ***
// Answers each peripheral bus access with a normal completion or a bus fault.
// Assumes the gate vector is the effective clock enable on the same clock.
`timescale 1ns/1ns
module unit_access_check
  import dsleep_gate_pkg::*;
#(
  parameter int UNITS = 32
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Effective gates and access.
  input wire logic [UNITS-1:0] gate_on,
  input wire unit_access_t access,
  // Verdict.
  output unit_verdict_t verdict_ff
);

  // One cycle after the access, a gated-off target gets a fault.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      verdict_ff <= '0;
    end else begin
      verdict_ff.done <= access.valid;
      verdict_ff.fault <= access.valid && !gate_on[access.unit_idx];
    end
  end

  AST_FAULT_ON_GATED: assert property (@(posedge aclk) disable iff (!aresetn)
    access.valid |=> verdict_ff.done && (verdict_ff.fault == !$past(gate_on[access.unit_idx])))
    else $error("Fault verdict does not match the gate state.");

endmodule

// *** core/dsleep_gate.sv ***
// Clock gating control for the serial, timer and two-wire units, with run, sleep and deep-sleep gate sets.
// Assumes an AXI4-Lite master on aclk and a power manager that reports the current power mode.
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ns
// How it works
// - A unit whose gate bit is one gets its clock enable and runs.
// - A unit whose gate bit is zero has its clock enable dropped and is held in reset.
// - A bus access to a unit whose clock is gated off is answered with a fault.
// - After reset every gate bit is zero, so every unit starts without a clock.
// - Separate gate registers exist for run, sleep and deep sleep.
// - Sleep and deep-sleep gates apply only while the automatic gating bit is set.
// - The deep-sleep gate register is a 32-bit word at offset 0x124 of the system control window.
// - Bit 14 gates the second two-wire module and bit 12 the first.
// - Bit 4 gates the synchronous serial port.
// - Bits 2, 1 and 0 gate the asynchronous serial ports two, one and zero.
// - Reserved bits are read-only and read zero.
module dsleep_gate
  import dsleep_gate_pkg::*;
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data.
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read.
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Power mode from the power manager.
  input wire power_mode_t power_mode,
  // Peripheral bus access check.
  input wire unit_access_t unit_access,
  output unit_verdict_t unit_verdict,
  // Per-unit clock enables and resets.
  output logic [31:0] unit_clk_en_ff,
  output logic [31:0] unit_hold_ff,
  // Interrupt.
  output logic irq
);

  // Gate registers and control state.
  logic [31:0] run_unit_clock_gate_ff;
  logic [31:0] sleep_unit_clock_gate_ff;
  logic [31:0] deep_sleep_unit_clock_gate_ff;
  logic [31:0] run_clock_config_ff;
  logic [EV_WIDTH-1:0] irq_status_ff;
  logic [EV_WIDTH-1:0] irq_mask_ff;
  logic [31:0] nxt_clk_en;
  power_mode_t mode_seen_ff;

  // Write channel state.
  logic aw_held_ff;
  logic w_held_ff;
  logic [11:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic wr_fire;

  // Read channel state.
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic rd_fire;
  logic [11:0] rd_ofs;
  logic status_read;

  // Byte-lane merge restricted to writable bits, used by every gate write.
  function automatic logic [31:0] merge_write(input logic [31:0] old_val, input logic [31:0] data,
                                              input logic [3:0] strb, input logic [31:0] wmask);
    logic [31:0] lanes;
    lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    merge_write = (old_val & ~(lanes & wmask)) | (data & lanes & wmask);
  endfunction

  // Word offset inside the window; upper address bits are ignored.
  function automatic logic [11:0] word_ofs(input logic [31:0] addr);
    word_ofs = {addr[11:2], 2'h0};
  endfunction

  // Write address and data are latched independently, in either order.
  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready = !w_held_ff && !bvalid_ff;
  assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      aw_addr_ff <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_ff <= 1'b1;
      aw_addr_ff <= word_ofs(s_axi_awaddr);
    end else if (wr_fire) begin
      aw_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_ff <= 1'b0;
      w_data_ff <= 32'h00000000;
      w_strb_ff <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_ff <= 1'b1;
      w_data_ff <= s_axi_wdata;
      w_strb_ff <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_ff <= 1'b0;
    end
  end

  // Write response; unmapped offsets get SLVERR and change nothing.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_ff <= 1'b1;
      case (aw_addr_ff)
        RUN_GATE_OFS, SLEEP_GATE_OFS, DEEP_GATE_OFS, CLK_CFG_OFS, IRQ_STATUS_OFS, IRQ_MASK_OFS: begin
          bresp_ff <= RESP_OKAY;
        end
        default: begin
          bresp_ff <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // Three gate sets kept apart, one per power mode; reserved bits never store.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_unit_clock_gate_ff <= GATE_RESET;
      sleep_unit_clock_gate_ff <= GATE_RESET;
      deep_sleep_unit_clock_gate_ff <= GATE_RESET;
    end else if (wr_fire) begin
      if (aw_addr_ff == RUN_GATE_OFS) begin
        run_unit_clock_gate_ff <= merge_write(run_unit_clock_gate_ff, w_data_ff, w_strb_ff, GATE_WMASK);
      end
      if (aw_addr_ff == SLEEP_GATE_OFS) begin
        sleep_unit_clock_gate_ff <= merge_write(sleep_unit_clock_gate_ff, w_data_ff, w_strb_ff, GATE_WMASK);
      end
      if (aw_addr_ff == DEEP_GATE_OFS) begin
        deep_sleep_unit_clock_gate_ff <= merge_write(deep_sleep_unit_clock_gate_ff, w_data_ff, w_strb_ff,
                                                     GATE_WMASK);
      end
    end
  end

  // Clock configuration holds only the automatic gating select.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_clock_config_ff <= CLK_CFG_RESET;
    end else if (wr_fire && aw_addr_ff == CLK_CFG_OFS) begin
      run_clock_config_ff <= merge_write(run_clock_config_ff, w_data_ff, w_strb_ff, CLK_CFG_WMASK);
    end
  end

  // Effective gate set; without automatic gating the run set applies in every mode.
  always_comb begin
    nxt_clk_en = run_unit_clock_gate_ff;
    if (run_clock_config_ff[AUTO_GATING_BIT]) begin
      case (power_mode)
        MODE_SLEEP: nxt_clk_en = sleep_unit_clock_gate_ff;
        MODE_DEEP: nxt_clk_en = deep_sleep_unit_clock_gate_ff;
        default: nxt_clk_en = run_unit_clock_gate_ff;
      endcase
    end
  end

  // Enables are registered so the clock gate cells see a glitch-free level.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unit_clk_en_ff <= GATE_RESET;
      unit_hold_ff <= ~GATE_RESET;
    end else begin
      unit_clk_en_ff <= nxt_clk_en;
      unit_hold_ff <= ~nxt_clk_en;
    end
  end

  // Peripheral access check against the enables the units really have.
  unit_access_check #(
    .UNITS(32)
  ) u_check (
    .aclk(aclk),
    .aresetn(aresetn),
    .gate_on(unit_clk_en_ff),
    .access(unit_access),
    .verdict_ff(unit_verdict)
  );

  // Read channel; one read at a time, answered the cycle after it is taken.
  assign s_axi_arready = !rvalid_ff;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign rd_ofs = word_ofs(s_axi_araddr);
  assign status_read = rd_fire && rd_ofs == IRQ_STATUS_OFS;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= RESP_OKAY;
      case (rd_ofs)
        RUN_GATE_OFS: rdata_ff <= run_unit_clock_gate_ff & GATE_WMASK;
        SLEEP_GATE_OFS: rdata_ff <= sleep_unit_clock_gate_ff & GATE_WMASK;
        DEEP_GATE_OFS: rdata_ff <= deep_sleep_unit_clock_gate_ff & GATE_WMASK;
        CLK_CFG_OFS: rdata_ff <= run_clock_config_ff;
        IRQ_STATUS_OFS: rdata_ff <= {{(32 - EV_WIDTH){1'b0}}, irq_status_ff};
        IRQ_MASK_OFS: rdata_ff <= {{(32 - EV_WIDTH){1'b0}}, irq_mask_ff};
        default: begin
          rdata_ff <= 32'h00000000;
          rresp_ff <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // Interrupt mask register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask_ff <= EV_RESET;
    end else if (wr_fire && aw_addr_ff == IRQ_MASK_OFS && w_strb_ff[0]) begin
      irq_mask_ff <= w_data_ff[EV_WIDTH-1:0];
    end
  end

  // Previous mode, to spot a mode change.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_seen_ff <= MODE_RUN;
    end else begin
      mode_seen_ff <= power_mode;
    end
  end

  // Sticky events, cleared by a status read; an event in the clearing cycle survives.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_ff <= EV_RESET;
    end else begin
      irq_status_ff[EV_FAULT_BIT] <= unit_verdict.fault || (irq_status_ff[EV_FAULT_BIT] && !status_read);
      irq_status_ff[EV_MODE_BIT] <= (power_mode != mode_seen_ff) || (irq_status_ff[EV_MODE_BIT] && !status_read);
    end
  end

  assign irq = |(irq_status_ff & irq_mask_ff);

  // Checks kept beside the logic they guard.
  sequence gate_written_s;
    wr_fire && aw_addr_ff == DEEP_GATE_OFS && w_strb_ff == 4'hF;
  endsequence

  AST_RESET_ZERO: assert property (@(posedge aclk)
    !aresetn |=> deep_sleep_unit_clock_gate_ff == GATE_RESET && unit_clk_en_ff == GATE_RESET)
    else $error("Gates not cleared by reset.");

  AST_RESERVED_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
    (deep_sleep_unit_clock_gate_ff & ~GATE_WMASK) == 32'h00000000)
    else $error("Reserved gate bit stored a one.");

  AST_DEEP_WRITE_BITS: assert property (@(posedge aclk) disable iff (!aresetn)
    gate_written_s |=> deep_sleep_unit_clock_gate_ff == ($past(w_data_ff) & GATE_WMASK))
    else $error("Deep gate write did not land on the gate bits.");

  AST_COUNTER_BITS: assert property (@(posedge aclk) disable iff (!aresetn)
    gate_written_s |=> deep_sleep_unit_clock_gate_ff[19:16] == $past(w_data_ff[19:16]))
    else $error("Counter gate bits wrong.");

  AST_SERIAL_BITS: assert property (@(posedge aclk) disable iff (!aresetn)
    gate_written_s |=> deep_sleep_unit_clock_gate_ff[4] == $past(w_data_ff[4])
    && deep_sleep_unit_clock_gate_ff[2:0] == $past(w_data_ff[2:0]))
    else $error("Serial gate bits wrong.");

  AST_DEEP_APPLIES: assert property (@(posedge aclk) disable iff (!aresetn)
    run_clock_config_ff[AUTO_GATING_BIT] && power_mode == MODE_DEEP
    |=> unit_clk_en_ff == $past(deep_sleep_unit_clock_gate_ff))
    else $error("Deep-sleep gates not applied in deep sleep.");

  AST_SLEEP_APPLIES: assert property (@(posedge aclk) disable iff (!aresetn)
    run_clock_config_ff[AUTO_GATING_BIT] && power_mode == MODE_SLEEP
    |=> unit_clk_en_ff == $past(sleep_unit_clock_gate_ff))
    else $error("Sleep gates not applied in sleep.");

  AST_NO_AUTO_RUN_SET: assert property (@(posedge aclk) disable iff (!aresetn)
    !run_clock_config_ff[AUTO_GATING_BIT] |=> unit_clk_en_ff == $past(run_unit_clock_gate_ff))
    else $error("Sleep gates used without automatic gating.");

  AST_HOLD_IS_INVERSE: assert property (@(posedge aclk) disable iff (!aresetn)
    unit_hold_ff == ~unit_clk_en_ff)
    else $error("Unit hold does not track the clock enable.");

  // Set wins over the read-clear, so a fault in the clearing cycle is never lost.
  AST_FAULT_STICKY: assert property (@(posedge aclk) disable iff (!aresetn)
    unit_verdict.fault |=> irq_status_ff[EV_FAULT_BIT])
    else $error("Fault event did not set its status bit.");

  AST_WRITE_ANSWER: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire |=> s_axi_bvalid)
    else $error("Write response missing after the write was taken.");

  // A response must stand until the master takes it, or a slow master loses it.
  AST_WRITE_HELD: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write response dropped before it was taken.");

  AST_READ_ANSWER: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_fire |=> s_axi_rvalid)
    else $error("Read response missing after the read was taken.");

  AST_READ_HELD: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("Read data dropped before it was taken.");

endmodule

// *** verif/unit_bus_model.sv ***
// Peripheral-side model: issues accesses to gated units and collects the verdict.
// Assumes the verdict is registered at the edge that takes the access and stands one cycle.
`timescale 1ns/1ns
module unit_bus_model
  import dsleep_gate_pkg::*;
(
  // Clock.
  input wire logic aclk,
  // Access out, verdict back.
  output unit_access_t access,
  input wire unit_verdict_t verdict
);
  // Idle from time zero so the block never sees an unknown request.
  initial begin
    access = '0;
  end

  // One access, called just after a rising edge; the index is scrambled when idle so a stale one proves nothing.
  task automatic touch(input logic [4:0] idx, output logic done, output logic fault);
    access <= '{valid: 1'b1, unit_idx: idx};
    @(posedge aclk);
    access <= '{valid: 1'b0, unit_idx: ~idx};
    @(negedge aclk);
    done = verdict.done;
    fault = verdict.fault;
    @(posedge aclk);
  endtask
endmodule

// *** verif/deep_sleep_clock_gating_test.sv ***
// Self-checking bench for the clock gating block, compared with a reference model at every result.
// Assumes the package and the peripheral-side model are compiled first.
`timescale 1ns/1ns
module deep_sleep_clock_gating_test
  import dsleep_gate_pkg::*;
();
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, unit_clk_en_ff, unit_hold_ff;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  power_mode_t power_mode = MODE_RUN;
  unit_access_t unit_access;
  unit_verdict_t unit_verdict;
  int bad_count = 0, samples_checked = 0, mode_m = 0;
  logic [31:0] run_m = '0, sleep_m = '0, deep_m = '0, cfg_m = '0, mask_m = '0;
  logic [1:0] stat_m = '0;
  int units[10] = '{GP_COUNTER3_BIT, GP_COUNTER2_BIT, GP_COUNTER1_BIT, GP_COUNTER0_BIT, TWO_WIRE1_BIT,
                    TWO_WIRE0_BIT, SYNC_SERIAL0_BIT, ASYNC_SERIAL2_BIT, ASYNC_SERIAL1_BIT, ASYNC_SERIAL0_BIT};

  // Free-running system clock.
  always #5 aclk = ~aclk;

  dsleep_gate dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .power_mode, .unit_access,
    .unit_verdict, .unit_clk_en_ff, .unit_hold_ff, .irq);
  unit_bus_model partner (.aclk(aclk), .access(unit_access), .verdict(unit_verdict));

  // Comparisons, one per kind of result.
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic print_verdict();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Ready is combinational, so it is sampled at the falling edge and the handshake lands on the next rising one.
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    logic ah, wh, bh;
    bh = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!bh) begin
      @(negedge aclk);
      ah = s_axi_awvalid && s_axi_awready;
      wh = s_axi_wvalid && s_axi_wready;
      bh = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ah, rh;
    rh = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!rh) begin
      @(negedge aclk);
      ah = s_axi_arvalid && s_axi_arready;
      rh = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ah) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  // Reference model of the registers and of the effective gate set.
  function automatic logic [31:0] upd(input logic [31:0] o, input logic [31:0] d, input logic [31:0] m,
                                      input logic [31:0] wm);
    return ((o & ~m) | (d & m)) & wm;
  endfunction
  function automatic logic [31:0] eff();
    if (!cfg_m[AUTO_GATING_BIT]) return run_m;
    return (mode_m == 1) ? sleep_m : (mode_m == 2) ? deep_m : run_m;
  endfunction
  task automatic bus_wr(input logic [11:0] ofs, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    logic [1:0] r;
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    axi_wr(SYSCTL_BASE | {20'h0, ofs}, d, s, r);
    chk_resp(r, er, "write response");
    case (ofs)
      RUN_GATE_OFS: run_m = upd(run_m, d, m, GATE_WMASK);
      SLEEP_GATE_OFS: sleep_m = upd(sleep_m, d, m, GATE_WMASK);
      DEEP_GATE_OFS: deep_m = upd(deep_m, d, m, GATE_WMASK);
      CLK_CFG_OFS: cfg_m = upd(cfg_m, d, m, CLK_CFG_WMASK);
      IRQ_MASK_OFS: mask_m = upd(mask_m, d, m, 32'h00000003);
      default: ;
    endcase
  endtask
  task automatic bus_rd(input logic [11:0] ofs, input logic [31:0] ed, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(SYSCTL_BASE | {20'h0, ofs}, d, r);
    chk_val(d, ed, "read data");
    chk_resp(r, er, "read response");
  endtask
  // Reading status clears it, so the interrupt must drop afterwards.
  task automatic read_status();
    bus_rd(IRQ_STATUS_OFS, {30'h0, stat_m}, RESP_OKAY);
    stat_m = '0;
    chk_val({31'h0, irq}, 32'h0, "interrupt after clear");
  endtask
  task automatic probe(input int idx);
    logic dn, ft, ex;
    logic [31:0] en;
    en = eff();
    ex = ~en[idx];
    partner.touch(idx[4:0], dn, ft);
    chk_val({31'h0, dn}, 32'h1, "verdict done");
    chk_val({31'h0, ft}, {31'h0, ex}, "verdict fault");
    if (ex) stat_m[EV_FAULT_BIT] = 1'b1;
    @(negedge aclk);
    chk_val({31'h0, irq}, {31'h0, |(stat_m & mask_m[1:0])}, "interrupt level");
    @(posedge aclk);
  endtask

  // Main sequence.
  initial begin
    int dummy;
    dummy = $urandom(95589);
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Outputs are read between edges, where they have settled.
    @(negedge aclk);
    chk_val(unit_clk_en_ff, 32'h0, "enables after reset");
    chk_val(unit_hold_ff, 32'hFFFFFFFF, "holds after reset");
    chk_val({31'h0, irq}, 32'h0, "interrupt after reset");
    @(posedge aclk);
    bus_rd(DEEP_GATE_OFS, GATE_RESET, RESP_OKAY);
    bus_wr(IRQ_MASK_OFS, 32'h3, 4'h1, RESP_OKAY);
    // Software that forgets to enable a unit first gets a fault.
    probe(ASYNC_SERIAL0_BIT);
    read_status();
    bus_wr(DEEP_GATE_OFS, 32'hFFFFFFFF, 4'hF, RESP_OKAY);
    bus_rd(DEEP_GATE_OFS, GATE_WMASK, RESP_OKAY);
    bus_wr(DEEP_GATE_OFS, 32'h0, 4'h4, RESP_OKAY);
    bus_rd(DEEP_GATE_OFS, deep_m, RESP_OKAY);
    bus_wr(12'h200, 32'hFFFFFFFF, 4'hF, RESP_SLVERR);
    bus_rd(12'h200, 32'h0, RESP_SLVERR);
    bus_wr(IRQ_STATUS_OFS, 32'h3, 4'hF, RESP_OKAY);
    // First two rounds run without auto gating, so the run set must rule in every mode.
    for (int i = 0; i < 8; i++) begin
      bus_wr(RUN_GATE_OFS, $urandom(), 4'hF, RESP_OKAY);
      bus_wr(SLEEP_GATE_OFS, $urandom(), 4'hF, RESP_OKAY);
      bus_wr(DEEP_GATE_OFS, $urandom(), 4'hF, RESP_OKAY);
      bus_wr(CLK_CFG_OFS, (i < 2) ? 32'h0 : ($urandom() | CLK_CFG_WMASK), 4'hF, RESP_OKAY);
      bus_wr(IRQ_MASK_OFS, $urandom(), 4'hF, RESP_OKAY);
      if ((i + 1) % 3 != mode_m) stat_m[EV_MODE_BIT] = 1'b1;
      mode_m = (i + 1) % 3;
      power_mode <= power_mode_t'(mode_m);
      repeat (3) @(posedge aclk);
      chk_val(unit_clk_en_ff, eff(), "clock enables");
      chk_val(unit_hold_ff, ~eff(), "unit holds");
      bus_rd(DEEP_GATE_OFS, deep_m, RESP_OKAY);
      foreach (units[k]) probe(units[k]);
      read_status();
      bus_rd(SLEEP_GATE_OFS, sleep_m, RESP_OKAY);
      bus_rd(RUN_GATE_OFS, run_m, RESP_OKAY);
      bus_rd(CLK_CFG_OFS, cfg_m, RESP_OKAY);
      bus_rd(IRQ_MASK_OFS, mask_m, RESP_OKAY);
    end
    print_verdict();
  end

  // A hang costs a mismatch and still ends in the verdict.
  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    print_verdict();
  end
endmodule
